// ===== compare_shadow_pkg.sv
// constants and helpers for the compare shadow load control block
package compare_shadow_pkg;

    // register indexes; byte address is four times the index
    localparam logic [5:0]  IDX_CTRL      = 6'h0E;
    localparam logic [5:0]  IDX_FINE      = 6'h10;
    localparam logic [5:0]  IDX_CMP_A     = 6'h12;
    localparam logic [5:0]  IDX_CMP_B     = 6'h14;

    // control register field positions
    localparam int          B_FULL_BIT    = 9;
    localparam int          A_FULL_BIT    = 8;
    localparam int          B_IMM_BIT     = 6;
    localparam int          A_IMM_BIT     = 4;
    localparam int          B_LS_LSB      = 2;
    localparam int          A_LS_LSB      = 0;

    // reset values
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [15:0] CMP_RESET     = 16'h0000;
    localparam logic [7:0]  FINE_RESET    = 8'h01;

    // load-select codes
    localparam logic [1:0]  LS_ZERO       = 2'h0;
    localparam logic [1:0]  LS_PERIOD     = 2'h1;
    localparam logic [1:0]  LS_EITHER     = 2'h2;
    localparam logic [1:0]  LS_FREEZE     = 2'h3;

    // shadow-to-active strobe from the counter events
    function automatic logic load_strobe(input logic [1:0] sel, input logic zero, input logic period);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            LS_ZERO:   hit = zero;
            LS_PERIOD: hit = period;
            LS_EITHER: hit = zero | period;
            LS_FREEZE: hit = 1'b0;
        endcase
        return hit;
    endfunction : load_strobe

    // byte-lane merge of a 16 bit value
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] new_v, input logic [1:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) res[7:0] = new_v[7:0];
        if (sel[1]) res[15:8] = new_v[15:8];
        return res;
    endfunction : merge16

endpackage : compare_shadow_pkg

// ===== compare_channel.sv
// one compare value with shadow, active register and full flag
`timescale 1ns/100ps
module compare_channel
    import compare_shadow_pkg::*;
#(
    parameter int CMP_W = 16
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    // cpu write and mode
    input  wire logic             wr_en_in,
    input  wire logic [CMP_W-1:0] wr_data_in,
    input  wire logic             immediate_in,
    input  wire logic [1:0]       load_select_in,
    // time-base events
    input  wire logic             count_zero_in,
    input  wire logic             count_period_in,
    // state
    output logic      [CMP_W-1:0] active_out,
    output logic      [CMP_W-1:0] shadow_out,
    output logic                  full_out
);

    logic [CMP_W-1:0] active_q, active_d;
    logic [CMP_W-1:0] shadow_q, shadow_d;
    logic             full_q, full_d;
    logic             strobe;

    // load strobe only exists in shadow mode; select ignored otherwise
    assign strobe = !immediate_in && load_strobe(load_select_in, count_zero_in, count_period_in);

    // next state: a write in the strobe cycle lands in shadow and keeps the flag set
    always_comb begin
        active_d = active_q;
        shadow_d = shadow_q;
        full_d   = full_q;
        if (strobe) begin
            active_d = shadow_q;
            full_d   = 1'b0;
        end
        if (wr_en_in && immediate_in) begin
            active_d = wr_data_in;
        end
        if (wr_en_in && !immediate_in) begin
            shadow_d = wr_data_in;
            full_d   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_q <= CMP_RESET[CMP_W-1:0];
            shadow_q <= CMP_RESET[CMP_W-1:0];
            full_q   <= 1'b0;
        end else begin
            active_q <= active_d;
            shadow_q <= shadow_d;
            full_q   <= full_d;
        end
    end

    assign active_out = active_q;
    assign shadow_out = shadow_q;
    assign full_out   = full_q;

    // checks on the channel
    sequence s_load;
        strobe && !wr_en_in;
    endsequence

    property p_load_moves;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_load |=> (active_q == $past(shadow_q)) && !full_q;
    endproperty
    a_load_moves: assert property (p_load_moves) else $error("load strobe did not move shadow");

    property p_write_sets_full;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (wr_en_in && !immediate_in) |=> full_q && (shadow_q == $past(wr_data_in));
    endproperty
    a_write_sets_full: assert property (p_write_sets_full) else $error("shadow write lost or flag not set");

    property p_immediate_write;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (wr_en_in && immediate_in) |=> (active_q == $past(wr_data_in)) && $stable(shadow_q);
    endproperty
    a_immediate_write: assert property (p_immediate_write) else $error("immediate write missed active");

    property p_freeze;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (!immediate_in && load_select_in == LS_FREEZE) |=> $stable(active_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("active changed while frozen");

    property p_immediate_no_load;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (immediate_in && !wr_en_in) |=> $stable(active_q) && $stable(full_q);
    endproperty
    a_immediate_no_load: assert property (p_immediate_no_load) else $error("load happened in immediate mode");

    property p_stable_between;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (!strobe && !(wr_en_in && immediate_in)) |=> $stable(active_q);
    endproperty
    a_stable_between: assert property (p_stable_between) else $error("active changed without strobe");

endmodule : compare_channel

// ===== compare_shadow_load_control.sv
// wishbone register front end with two shadowed compare channels
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
module compare_shadow_load_control
    import compare_shadow_pkg::*;
#(
    parameter int CMP_W = 16
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    // wishbone classic slave
    input  wire logic             wb_cyc_in,
    input  wire logic             wb_stb_in,
    input  wire logic             wb_we_in,
    input  wire logic [7:0]       wb_adr_in,
    input  wire logic [3:0]       wb_sel_in,
    input  wire logic [31:0]      wb_dat_in,
    output logic      [31:0]      wb_dat_out,
    output logic                  wb_ack_out,
    // time-base events, one-cycle pulses
    input  wire logic             count_zero_in,
    input  wire logic             count_period_in,
    // values to the compare logic
    output logic      [CMP_W-1:0] cmp_a_active_out,
    output logic      [CMP_W-1:0] cmp_b_active_out,
    output logic      [7:0]       fine_part_out
);

    logic [15:0] ctrl_q, ctrl_d;
    logic [7:0]  fine_q, fine_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        req, commit;
    logic [5:0]  idx;
    logic        a_imm, b_imm;
    logic [1:0]  a_ls, b_ls;
    logic        a_wr, b_wr, a_wr16, a_wr32;
    logic [15:0] a_vis, b_vis, a_wdata, b_wdata;
    logic [CMP_W-1:0] a_active, a_shadow, b_active, b_shadow;
    logic        a_full, b_full;

    // bus decode; writes commit on the edge that shows ack to the master
    assign req    = wb_cyc_in && wb_stb_in;
    assign commit = req && ack_q && wb_we_in;
    assign idx    = wb_adr_in[7:2];

    assign a_imm = ctrl_q[A_IMM_BIT];
    assign b_imm = ctrl_q[B_IMM_BIT];
    assign a_ls  = ctrl_q[A_LS_LSB +: 2];
    assign b_ls  = ctrl_q[B_LS_LSB +: 2];

    // what software sees: shadow in shadow mode, active in immediate mode
    assign a_vis = 16'(a_imm ? a_active : a_shadow);
    assign b_vis = 16'(b_imm ? b_active : b_shadow);

    // compare A writes: own word, or upper half of the fine-part word
    assign a_wr16  = commit && idx == IDX_CMP_A && wb_sel_in[1:0] != 2'h0;
    assign a_wr32  = commit && idx == IDX_FINE && wb_sel_in[3:2] != 2'h0;
    assign a_wr    = a_wr16 || a_wr32;
    assign a_wdata = a_wr32 ? merge16(a_vis, wb_dat_in[31:16], wb_sel_in[3:2])
                            : merge16(a_vis, wb_dat_in[15:0], wb_sel_in[1:0]);
    assign b_wr    = commit && idx == IDX_CMP_B && wb_sel_in[1:0] != 2'h0;
    assign b_wdata = merge16(b_vis, wb_dat_in[15:0], wb_sel_in[1:0]);

    // register next state; in the control word only mode and load-select bits take writes
    always_comb begin
        ctrl_d = ctrl_q;
        fine_d = fine_q;
        if (commit && idx == IDX_CTRL && wb_sel_in[0]) begin
            ctrl_d[A_LS_LSB +: 2] = wb_dat_in[A_LS_LSB +: 2];
            ctrl_d[B_LS_LSB +: 2] = wb_dat_in[B_LS_LSB +: 2];
            ctrl_d[A_IMM_BIT]     = wb_dat_in[A_IMM_BIT];
            ctrl_d[B_IMM_BIT]     = wb_dat_in[B_IMM_BIT];
        end
        // fine-only write leaves the compare A flag alone
        if (commit && idx == IDX_FINE && wb_sel_in[1]) begin
            fine_d = wb_dat_in[15:8];
        end
    end

    // bus answer: ack one cycle after the request, dropped the cycle after
    always_comb begin
        ack_d   = req && !ack_q;
        rdata_d = rdata_q;
        if (req && !ack_q) begin
            unique case (idx)
                IDX_CTRL: begin
                    rdata_d = 32'h0000_0000;
                    rdata_d[B_FULL_BIT]     = b_full;
                    rdata_d[A_FULL_BIT]     = a_full;
                    rdata_d[B_IMM_BIT]      = b_imm;
                    rdata_d[A_IMM_BIT]      = a_imm;
                    rdata_d[B_LS_LSB +: 2]  = b_ls;
                    rdata_d[A_LS_LSB +: 2]  = a_ls;
                end
                IDX_FINE:  rdata_d = {a_vis, fine_q, 8'h00};
                IDX_CMP_A: rdata_d = {16'h0000, a_vis};
                IDX_CMP_B: rdata_d = {16'h0000, b_vis};
                default:   rdata_d = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q  <= CTRL_RESET;
            fine_q  <= FINE_RESET;
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q  <= ctrl_d;
            fine_q  <= fine_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    compare_channel #(.CMP_W(CMP_W)) u_chan_a (
        .sys_clk_in     (sys_clk_in),
        .reset_n_in     (reset_n_in),
        .wr_en_in       (a_wr),
        .wr_data_in     (a_wdata[CMP_W-1:0]),
        .immediate_in   (a_imm),
        .load_select_in (a_ls),
        .count_zero_in  (count_zero_in),
        .count_period_in(count_period_in),
        .active_out     (a_active),
        .shadow_out     (a_shadow),
        .full_out       (a_full)
    );

    compare_channel #(.CMP_W(CMP_W)) u_chan_b (
        .sys_clk_in     (sys_clk_in),
        .reset_n_in     (reset_n_in),
        .wr_en_in       (b_wr),
        .wr_data_in     (b_wdata[CMP_W-1:0]),
        .immediate_in   (b_imm),
        .load_select_in (b_ls),
        .count_zero_in  (count_zero_in),
        .count_period_in(count_period_in),
        .active_out     (b_active),
        .shadow_out     (b_shadow),
        .full_out       (b_full)
    );

    assign wb_ack_out       = ack_q;
    assign wb_dat_out       = rdata_q;
    assign cmp_a_active_out = a_active;
    assign cmp_b_active_out = b_active;
    assign fine_part_out    = fine_q;

    // checks on the front end
    sequence s_new_req;
        req && !ack_q;
    endsequence

    property p_ack_timing;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        s_new_req |=> wb_ack_out ##1 !wb_ack_out;
    endproperty
    a_ack_timing: assert property (p_ack_timing) else $error("ack not one cycle after request");

    property p_full_write_sets_a;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (commit && idx == IDX_FINE && wb_sel_in == 4'hF && !a_imm) |=> a_full;
    endproperty
    a_full_write_sets_a: assert property (p_full_write_sets_a) else $error("32 bit write left A flag clear");

    property p_fine_only_keeps_flag;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (commit && idx == IDX_FINE && wb_sel_in[3:2] == 2'h0 && !count_zero_in && !count_period_in)
            |=> a_full == $past(a_full);
    endproperty
    a_fine_only_keeps_flag: assert property (p_fine_only_keeps_flag) else $error("fine-only write moved A flag");

    property p_reserved_zero;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (s_new_req and (idx == IDX_CTRL)) |=> wb_dat_out[31:10] == 22'h0 && !wb_dat_out[7] && !wb_dat_out[5];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bits not zero");

    property p_flags_read_only;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (commit && idx == IDX_CTRL && wb_sel_in[1] && wb_dat_in[B_FULL_BIT] && wb_dat_in[A_FULL_BIT]
            && !b_full && !a_full && !b_wr && !a_wr) |=> !b_full && !a_full;
    endproperty
    a_flags_read_only: assert property (p_flags_read_only) else $error("software set a shadow flag");

    property p_b_load_on_zero;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (!b_imm && b_ls == LS_ZERO && count_zero_in && b_full && !b_wr) |=> !b_full && b_active == $past(b_shadow);
    endproperty
    a_b_load_on_zero: assert property (p_b_load_on_zero) else $error("B did not load on counter zero");

    property p_a_load_on_period;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (!a_imm && a_ls == LS_PERIOD && count_period_in && !a_wr) |=> !a_full && a_active == $past(a_shadow);
    endproperty
    a_a_load_on_period: assert property (p_a_load_on_period) else $error("A did not load on period");

endmodule : compare_shadow_load_control

// ===== compare_shadow_load_control_bench.sv
// self-checking bench for the compare shadow load control block
`timescale 1ns/100ps
module compare_shadow_load_control_bench;
    import compare_shadow_pkg::*;

    // design drive and observation
    logic        sys_clk_in;
    logic        reset_n_in;
    logic        wb_cyc_in;
    logic        wb_stb_in;
    logic        wb_we_in;
    logic [7:0]  wb_adr_in;
    logic [3:0]  wb_sel_in;
    logic [31:0] wb_dat_in;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out;
    logic        count_zero_in;
    logic        count_period_in;
    logic [15:0] cmp_a_active_out;
    logic [15:0] cmp_b_active_out;
    logic [7:0]  fine_part_out;
    // expected read data and the bench's own model of the block
    logic [31:0] exp_q[$];
    int          failures;
    int          num_checks;
    logic [15:0] sh_a, sh_b, act_a, act_b;
    logic        fl_a, fl_b, ia, ib;
    logic [1:0]  la, lb;
    logic [15:0] v;

    compare_shadow_load_control #(.CMP_W(16)) dut_u (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .count_zero_in(count_zero_in),
        .count_period_in(count_period_in), .cmp_a_active_out(cmp_a_active_out),
        .cmp_b_active_out(cmp_b_active_out), .fine_part_out(fine_part_out));

    // 125 MHz clock
    initial sys_clk_in = 1'b0;
    always #4 sys_clk_in = ~sys_clk_in;

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val

    // read results: oldest note is compared when a read is acknowledged
    always @(posedge sys_clk_in) begin
        if (wb_ack_out === 1'b1 && wb_we_in === 1'b0) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("mismatch at %0t: read answer with nothing expected", $time);
            end else begin
                check_val(wb_dat_out, exp_q.pop_front(), "read data");
            end
        end
    end

    // one classic cycle; called just after a rising edge, leaves one idle cycle behind
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= adr;
        wb_sel_in <= sel;
        wb_dat_in <= dat;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        // released address and data lines show inverted values so stale data cannot pass
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in  <= 1'b0;
        wb_adr_in <= ~adr;
        wb_dat_in <= ~dat;
        @(posedge sys_clk_in);
    endtask : wb_cycle

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb_cycle(1'b0, adr, 4'hF, 32'h0000_0000);
    endtask : rd

    function automatic logic [31:0] ctrl_exp();
        return {22'h0, fl_b, fl_a, 1'b0, ib, 1'b0, ia, lb, la};
    endfunction : ctrl_exp

    task automatic set_ctrl(input logic a_imm, input logic b_imm, input logic [1:0] a_ls, input logic [1:0] b_ls);
        ia = a_imm;
        ib = b_imm;
        la = a_ls;
        lb = b_ls;
        wb_cycle(1'b1, 8'h38, 4'h3, {16'h0, 9'h0, b_imm, 1'b0, a_imm, b_ls, a_ls});
    endtask : set_ctrl

    // 16 bit compare write; shadow mode fills the shadow, immediate mode hits the active value
    task automatic wr_cmp(input logic is_b, input logic [15:0] val);
        wb_cycle(1'b1, is_b ? 8'h50 : 8'h48, 4'h3, {16'hA5A5, val});
        if (is_b && !ib) begin
            sh_b = val;
            fl_b = 1'b1;
        end else if (is_b) act_b = val;
        else if (!ia) begin
            sh_a = val;
            fl_a = 1'b1;
        end else act_a = val;
    endtask : wr_cmp

    function automatic logic hit(input logic [1:0] ls, input logic z, input logic p);
        return (ls == 2'h0 && z) || (ls == 2'h1 && p) || (ls == 2'h2 && (z || p));
    endfunction : hit

    // one-cycle counter events, model updated from the selected code
    task automatic pulse(input logic z, input logic p);
        count_zero_in   <= z;
        count_period_in <= p;
        @(posedge sys_clk_in);
        count_zero_in   <= 1'b0;
        count_period_in <= 1'b0;
        if (!ia && hit(la, z, p)) begin
            act_a = sh_a;
            fl_a  = 1'b0;
        end
        if (!ib && hit(lb, z, p)) begin
            act_b = sh_b;
            fl_b  = 1'b0;
        end
        @(posedge sys_clk_in);
    endtask : pulse

    task automatic check_act();
        check_val({16'h0, cmp_a_active_out}, {16'h0, act_a}, "active a");
        check_val({16'h0, cmp_b_active_out}, {16'h0, act_b}, "active b");
    endtask : check_act

    task automatic give_verdict();
        // a read that never came back is a failure too
        if (exp_q.size() != 0) begin
            failures++;
            $display("mismatch at %0t: expected reads never answered", $time);
        end
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // watchdog well beyond the expected run
    initial begin
        #200000;
        failures++;
        give_verdict();
    end

    // main sequence
    initial begin
        {reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, count_zero_in, count_period_in} = 6'h00;
        wb_adr_in = 8'h00;
        wb_sel_in = 4'h0;
        wb_dat_in = 32'h0000_0000;
        {failures, num_checks} = {32'd0, 32'd0};
        {sh_a, sh_b, act_a, act_b} = 64'h0;
        {fl_a, fl_b, ia, ib, la, lb} = 8'h00;
        void'($urandom(10062));
        repeat (6) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        @(posedge sys_clk_in);
        rd(8'h38, 32'h0000_0000);
        rd(8'h40, 32'h0000_0100);
        rd(8'h48, 32'h0000_0000);
        rd(8'h50, 32'h0000_0000);
        rd(8'h7C, 32'h0000_0000);
        check_val({24'h0, fine_part_out}, 32'h0000_0001, "fine reset");
        check_act();
        $display("test reset values done");
        // every load-select code on both channels, second write overwrites the pending one
        for (int c = 0; c < 4; c++) begin
            set_ctrl(1'b0, 1'b0, 2'(c), 2'(c));
            wr_cmp(1'b0, 16'($urandom()));
            wr_cmp(1'b0, 16'($urandom()));
            wr_cmp(1'b1, 16'($urandom()));
            wr_cmp(1'b1, 16'($urandom()));
            rd(8'h38, ctrl_exp());
            rd(8'h48, {16'h0, sh_a});
            rd(8'h50, {16'h0, sh_b});
            check_act();
            pulse(1'b1, 1'b0);
            check_act();
            rd(8'h38, ctrl_exp());
            pulse(1'b0, 1'b1);
            check_act();
            rd(8'h38, ctrl_exp());
        end
        $display("test load select codes done");
        // fine-only write leaves the flag, wide write through the fine word sets it
        set_ctrl(1'b0, 1'b0, 2'h0, 2'h0);
        pulse(1'b1, 1'b0);
        wb_cycle(1'b1, 8'h40, 4'h3, 32'h0000_5A00);
        rd(8'h38, ctrl_exp());
        check_val({24'h0, fine_part_out}, 32'h0000_005A, "fine write");
        v = 16'($urandom());
        wb_cycle(1'b1, 8'h40, 4'hF, {v, 16'h5A00});
        sh_a = v;
        fl_a = 1'b1;
        rd(8'h38, ctrl_exp());
        rd(8'h40, {v, 16'h5A00});
        pulse(1'b1, 1'b0);
        check_act();
        $display("test wide compare write done");
        // immediate mode: writes land at once, events ignored
        set_ctrl(1'b1, 1'b1, 2'h0, 2'h0);
        wr_cmp(1'b0, 16'($urandom()));
        wr_cmp(1'b1, 16'($urandom()));
        check_act();
        rd(8'h38, ctrl_exp());
        pulse(1'b1, 1'b1);
        check_act();
        rd(8'h48, {16'h0, act_a});
        rd(8'h50, {16'h0, act_b});
        $display("test immediate mode done");
        // reserved and flag bits ignore writes
        wb_cycle(1'b1, 8'h38, 4'hF, 32'hFFFF_FFFF);
        {ia, ib, la, lb} = 6'h3F;
        rd(8'h38, ctrl_exp());
        $display("test reserved bits done");
        give_verdict();
    end

endmodule : compare_shadow_load_control_bench
